// >>> hdl/pcm_pkg.sv
/*
  Constants for the channel-zero mode and split-oscillator control registers.
  Assumes byte-wide registers on the serial control port's internal access strobes.
*/
`default_nettype none
package pcm_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [15:0] OSC_SPLIT_CFG_ADDR  = 16'h021E;
  localparam logic [15:0] PLL0_MODE_REF_ADDR  = 16'h021E;
  localparam logic [15:0] PLL0_CONTROL_ADDR   = 16'h021F;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0]  OSC_SPLIT_CFG_RST   = 8'h00;
  localparam logic [7:0]  PLL0_MODE_REF_RST   = 8'h00;
  localparam logic [7:0]  PLL0_CONTROL_RST    = 8'h08;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int          REF_MSB             = 7;
  localparam int          REF_LSB             = 4;
  localparam int          SPLIT_EN_BIT        = 0;
  localparam int          MODE_MSB            = 2;
  localparam int          AUTO_CAP_BIT        = 4;
  localparam int          REALIGN_BIT         = 1;
  localparam int          CTRL_FIXED_BIT      = 3;
  // ------------------------------------------------------------
  // references and mode codes
  // ------------------------------------------------------------
  localparam int          REF_COUNT           = 10;
  localparam logic [2:0]  MODE_FREERUN        = 3'h0;
  localparam logic [2:0]  MODE_HOLDOVER       = 3'h1;
  localparam logic [2:0]  MODE_FORCED         = 3'h2;
  localparam logic [2:0]  MODE_AUTO           = 3'h3;
  localparam logic [2:0]  MODE_NCO            = 3'h4;
endpackage
`default_nettype wire

// >>> hdl/pcm_regs.sv
/*
  Mode, forced reference, offset capture and realign control for PLL channel zero,
  plus split-oscillator configuration. Assumes the serial control port decodes
  pages and hands over byte accesses on sys_clk; all neighbour inputs are on sys_clk.
*/
// What this block does
// - split-oscillator reference index nibble picks the oscillator source input.
// - nonexistent split-oscillator reference index falls back to reference input zero.
// - split-oscillator config bit 0 turns split-oscillator operation off or on.
// - a write changing the split-oscillator enable triggers a warm start.
// - after that warm start the revision register is cleared.
// - mode field selects freerun, holdover, forced lock, automatic or NCO.
// - mode codes 101 to 111 behave as automatic mode.
// - forced lock mode locks only to the mode register's reference nibble.
// - forced reference failing in forced lock mode moves channel to holdover.
// - nonexistent forced reference index selects reference input zero.
// - outside forced lock mode the forced reference index is ignored.
// - control bit 4 disables or enables automatic oscillator-offset capture.
// - with capture on, entering holdover or NCO mode from freerun, forced lock or automatic mode copies the frequency offset.
// - realign clear keeps output phase across switches, hitless.
// - realign set aligns outputs to the reset position from phase shift.
`timescale 1ns/1ps
`default_nettype none
module pcm_regs (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [15:0] regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        splitCfgSel,
  input  wire logic        warmStartDone,
  input  wire logic [9:0]  refFailed,
  output logic      [7:0]  regRdData,
  output logic             splitOscillatorEnable,
  output logic      [3:0]  splitOscillatorRef,
  output logic             warmStart,
  output logic             revisionClear,
  output logic      [2:0]  pllChannelZeroMode,
  output logic      [3:0]  pllChannelZeroRef,
  output logic             pllChannelZeroRefForced,
  output logic             pllChannelZeroHoldover,
  output logic             freqOffsetCapture,
  output logic             outputRealign
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic       splitEn;
    logic [3:0] splitRef;
    logic [2:0] modeRaw;
    logic [2:0] modeEff;
    logic [3:0] forceRef;
    logic       autoCap;
    logic       realign;
    logic [7:0] rdData;
    logic       warm;
    logic       revPending;
    logic       revClr;
    logic       capReq;
    logic       holdover;
    logic [3:0] splitSrc;
    logic [3:0] chanRef;
    logic       refForced;
  } pcm_state_s;

  pcm_state_s st;
  pcm_state_s next_st;

  // out-of-range index maps to reference input zero
  function automatic logic [3:0] pcmEffRef(input logic [3:0] idx);
    pcmEffRef = (idx < 4'(pcm_pkg::REF_COUNT)) ? idx : 4'h0;
  endfunction

  function automatic logic [2:0] pcmEffMode(input logic [2:0] code);
    pcmEffMode = (code > pcm_pkg::MODE_NCO) ? pcm_pkg::MODE_AUTO : code;
  endfunction

  function automatic logic pcmIsCapMode(input logic [2:0] m);
    pcmIsCapMode = (m == pcm_pkg::MODE_HOLDOVER) || (m == pcm_pkg::MODE_NCO);
  endfunction

  logic wrSplit;
  logic wrMode;
  logic wrCtrl;
  logic rdSplit;
  logic rdMode;
  logic rdCtrl;
  logic [2:0] newMode;
  logic [3:0] newRef;

  // both registers share one offset; the page logic says which one is meant
  assign wrSplit = regWrite && regAddr == pcm_pkg::OSC_SPLIT_CFG_ADDR && splitCfgSel;
  assign wrMode  = regWrite && regAddr == pcm_pkg::PLL0_MODE_REF_ADDR && !splitCfgSel;
  assign wrCtrl  = regWrite && regAddr == pcm_pkg::PLL0_CONTROL_ADDR;
  assign rdSplit = regAddr == pcm_pkg::OSC_SPLIT_CFG_ADDR && splitCfgSel;
  assign rdMode  = regAddr == pcm_pkg::PLL0_MODE_REF_ADDR && !splitCfgSel;
  assign rdCtrl  = regAddr == pcm_pkg::PLL0_CONTROL_ADDR;
  assign newMode = pcmEffMode(regWrData[pcm_pkg::MODE_MSB:0]);
  assign newRef  = pcmEffRef(regWrData[pcm_pkg::REF_MSB:pcm_pkg::REF_LSB]);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.warm = 1'b0;
    next_st.revClr = 1'b0;
    next_st.capReq = 1'b0;
    if (wrSplit) begin
      next_st.splitEn  = regWrData[pcm_pkg::SPLIT_EN_BIT];
      next_st.splitRef = regWrData[pcm_pkg::REF_MSB:pcm_pkg::REF_LSB];
      next_st.splitSrc = newRef;
      // only a change of the enable restarts, rewriting the same value does not
      next_st.warm = regWrData[pcm_pkg::SPLIT_EN_BIT] != st.splitEn;
    end
    if (wrMode) begin
      next_st.modeRaw  = regWrData[pcm_pkg::MODE_MSB:0];
      next_st.modeEff  = newMode;
      next_st.forceRef = regWrData[pcm_pkg::REF_MSB:pcm_pkg::REF_LSB];
      // index is kept for readback but only steers the channel in forced lock mode
      next_st.refForced = newMode == pcm_pkg::MODE_FORCED;
      next_st.chanRef = (newMode == pcm_pkg::MODE_FORCED) ? newRef : 4'h0;
      // capture fires on entry only, not on a rewrite of the same mode
      next_st.capReq = st.autoCap && pcmIsCapMode(newMode)
                       && !pcmIsCapMode(st.modeEff);
    end
    if (wrCtrl) begin
      next_st.autoCap = regWrData[pcm_pkg::AUTO_CAP_BIT];
      next_st.realign = regWrData[pcm_pkg::REALIGN_BIT];
    end
    // revision clear waits for the warm start to finish; a new start wins
    if (st.revPending && warmStartDone) begin
      next_st.revPending = 1'b0;
      next_st.revClr = 1'b1;
    end
    if (st.warm) begin
      next_st.revPending = 1'b1;
    end
    next_st.holdover = (st.modeEff == pcm_pkg::MODE_HOLDOVER)
                       || (st.refForced && refFailed[st.chanRef]);
    next_st.rdData = 8'h00;
    if (regRead) begin
      // unused and reserved bits come back as zero, except control bit 3, which reads one
      if (rdSplit) begin
        next_st.rdData = {st.splitRef, 3'h0, st.splitEn};
      end else if (rdMode) begin
        next_st.rdData = {st.forceRef, 1'b0, st.modeRaw};
      end else if (rdCtrl) begin
        next_st.rdData = {3'h0, st.autoCap, 1'b1, 1'b0, st.realign, 1'b0};
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st.splitEn    <= pcm_pkg::OSC_SPLIT_CFG_RST[pcm_pkg::SPLIT_EN_BIT];
      st.splitRef   <= pcm_pkg::OSC_SPLIT_CFG_RST[pcm_pkg::REF_MSB:pcm_pkg::REF_LSB];
      st.modeRaw    <= pcm_pkg::PLL0_MODE_REF_RST[pcm_pkg::MODE_MSB:0];
      st.modeEff    <= pcm_pkg::PLL0_MODE_REF_RST[pcm_pkg::MODE_MSB:0];
      st.forceRef   <= pcm_pkg::PLL0_MODE_REF_RST[pcm_pkg::REF_MSB:pcm_pkg::REF_LSB];
      st.autoCap    <= pcm_pkg::PLL0_CONTROL_RST[pcm_pkg::AUTO_CAP_BIT];
      st.realign    <= pcm_pkg::PLL0_CONTROL_RST[pcm_pkg::REALIGN_BIT];
      st.rdData     <= 8'h00;
      st.warm       <= 1'b0;
      st.revPending <= 1'b0;
      st.revClr     <= 1'b0;
      st.capReq     <= 1'b0;
      st.holdover   <= 1'b0;
      st.splitSrc   <= pcm_pkg::OSC_SPLIT_CFG_RST[pcm_pkg::REF_MSB:pcm_pkg::REF_LSB];
      // reset mode is freerun, so no forced index steers the channel
      st.chanRef    <= 4'h0;
      st.refForced  <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign regRdData               = st.rdData;
  assign splitOscillatorEnable   = st.splitEn;
  assign splitOscillatorRef      = st.splitSrc;
  assign warmStart               = st.warm;
  assign revisionClear           = st.revClr;
  assign pllChannelZeroMode      = st.modeEff;
  assign pllChannelZeroRefForced = st.refForced;
  assign pllChannelZeroRef       = st.chanRef;
  assign pllChannelZeroHoldover  = st.holdover;
  assign freqOffsetCapture       = st.capReq;
  assign outputRealign           = st.realign;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_split_ref_fallback;
    splitOscillatorRef == ((st.splitRef < 4'(pcm_pkg::REF_COUNT)) ? st.splitRef : 4'h0);
  endproperty
  a_split_ref_fallback: assert property (p_split_ref_fallback)
    else $error("split reference not mapped to input zero");

  property p_warm_on_change;
    wrSplit && (regWrData[0] != splitOscillatorEnable) |=> warmStart;
  endproperty
  a_warm_on_change: assert property (p_warm_on_change)
    else $error("enable change gave no warm start");

  property p_no_warm_same;
    wrSplit && (regWrData[0] == splitOscillatorEnable) |=> !warmStart;
  endproperty
  a_no_warm_same: assert property (p_no_warm_same)
    else $error("warm start without enable change");

  property p_enable_follows;
    wrSplit |=> splitOscillatorEnable == $past(regWrData[0]);
  endproperty
  a_enable_follows: assert property (p_enable_follows)
    else $error("split enable did not take written bit");

  property p_rev_clear_after_warm;
    warmStart ##1 (warmStartDone && !warmStart) |=> revisionClear;
  endproperty
  a_rev_clear_after_warm: assert property (p_rev_clear_after_warm)
    else $error("revision not cleared after warm start");

  property p_rev_clear_cause;
    revisionClear |-> $past(st.revPending) && $past(warmStartDone);
  endproperty
  a_rev_clear_cause: assert property (p_rev_clear_cause)
    else $error("revision cleared without finished warm start");

  property p_invalid_is_auto;
    wrMode && regWrData[2:0] > 3'h4 |=> pllChannelZeroMode == pcm_pkg::MODE_AUTO;
  endproperty
  a_invalid_is_auto: assert property (p_invalid_is_auto)
    else $error("invalid mode not treated as automatic");

  property p_ref_ignored;
    pllChannelZeroMode != pcm_pkg::MODE_FORCED |-> pllChannelZeroRef == 4'h0;
  endproperty
  a_ref_ignored: assert property (p_ref_ignored)
    else $error("forced reference used outside forced mode");

  property p_forced_fail_holdover;
    pllChannelZeroRefForced && refFailed[pllChannelZeroRef]
      && !wrMode |=> pllChannelZeroHoldover;
  endproperty
  a_forced_fail_holdover: assert property (p_forced_fail_holdover)
    else $error("failed forced reference did not enter holdover");

  property p_capture_entry;
    wrMode && st.autoCap
      && (regWrData[2:0] == pcm_pkg::MODE_NCO || regWrData[2:0] == pcm_pkg::MODE_HOLDOVER)
      && pllChannelZeroMode != pcm_pkg::MODE_HOLDOVER
      && pllChannelZeroMode != pcm_pkg::MODE_NCO |=> freqOffsetCapture;
  endproperty
  a_capture_entry: assert property (p_capture_entry)
    else $error("no offset capture on entry to holdover or NCO mode");

  property p_capture_pulse;
    freqOffsetCapture |=> !freqOffsetCapture;
  endproperty
  a_capture_pulse: assert property (p_capture_pulse)
    else $error("offset capture request longer than one cycle");

  property p_forced_flag;
    pllChannelZeroRefForced == (pllChannelZeroMode == pcm_pkg::MODE_FORCED);
  endproperty
  a_forced_flag: assert property (p_forced_flag)
    else $error("forced flag disagrees with mode");

  property p_forced_ref_map;
    pllChannelZeroRefForced
      |-> pllChannelZeroRef == ((st.forceRef < 4'(pcm_pkg::REF_COUNT)) ? st.forceRef : 4'h0);
  endproperty
  a_forced_ref_map: assert property (p_forced_ref_map)
    else $error("forced reference not mapped to input zero");

  property p_holdover_mode;
    pllChannelZeroMode == pcm_pkg::MODE_HOLDOVER |=> pllChannelZeroHoldover;
  endproperty
  a_holdover_mode: assert property (p_holdover_mode)
    else $error("forced holdover mode without holdover");

  property p_realign_follows;
    wrCtrl |=> outputRealign == $past(regWrData[pcm_pkg::REALIGN_BIT]);
  endproperty
  a_realign_follows: assert property (p_realign_follows)
    else $error("realign did not take written bit");

  property p_capture_off;
    wrMode && !st.autoCap |=> !freqOffsetCapture;
  endproperty
  a_capture_off: assert property (p_capture_off)
    else $error("offset capture while disabled");

  property p_ctrl_readback;
    regRead && rdCtrl && !regWrite |=> regRdData[7:5] == 3'h0 && regRdData[0] == 1'b0
      && regRdData[1] == outputRealign && regRdData[3] == 1'b1
      && regRdData[4] == st.autoCap;
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback)
    else $error("control readback wrong or reserved bits set");

endmodule // pcm_regs
`default_nettype wire

// >>> test/pcm_host.sv
/*
  Host model on the serial control port: single byte write and read cycles.
  Assumes the bench calls acc and that the device takes requests on rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
module pcm_host (
  input  wire logic        sys_clk,
  output logic             regWrite,
  output logic             regRead,
  output logic      [15:0] regAddr,
  output logic      [7:0]  regWrData,
  output logic             splitCfgSel
);
  initial begin
    regWrite    = 1'b0;
    regRead     = 1'b0;
    regAddr     = 16'h0000;
    regWrData   = 8'h00;
    splitCfgSel = 1'b0;
  end

  // revision is the caller's business before it sets split enable
  // realign is set by the caller after many switches
  task automatic acc(input logic w, input logic [15:0] a, input logic s,
                     input logic [7:0] d);
    @(negedge sys_clk);
    regWrite    = w;
    regRead     = !w;
    regAddr     = a;
    splitCfgSel = s;
    regWrData   = d;
    @(negedge sys_clk);
    regWrite    = 1'b0;
    regRead     = 1'b0;
    // released lines must not keep the last value
    regAddr     = ~a;
    regWrData   = ~d;
  endtask
endmodule // pcm_host
`default_nettype wire

// >>> test/pcm_regs_tb_top.sv
/*
  Self-checking bench for the channel-zero mode and split-oscillator registers.
  Assumes pcm_host drives the register strobes; reads are checked from a queue.
*/
`timescale 1ns/1ps
`default_nettype none
module pcm_regs_tb_top;
  logic        sys_clk;
  logic        rst;
  logic        regWrite, regRead, splitCfgSel, warmStartDone;
  logic [15:0] regAddr;
  logic [7:0]  regWrData, regRdData;
  logic [9:0]  refFailed;
  logic        splitOscillatorEnable, warmStart, revisionClear;
  logic [3:0]  splitOscillatorRef, pllChannelZeroRef, r;
  logic [2:0]  pllChannelZeroMode, e, pe;
  logic        pllChannelZeroRefForced, pllChannelZeroHoldover;
  logic        freqOffsetCapture, outputRealign, en, pen;
  logic        rdSeen = 1'b0;
  logic [7:0]  q[$];
  logic [2:0]  seq [10] = '{3'h0, 3'h4, 3'h1, 3'h3, 3'h1, 3'h2, 3'h5, 3'h6, 3'h7, 3'h4};
  int          error_cnt = 0;
  int          n_compared = 0;

  pcm_host host (.sys_clk, .regWrite, .regRead, .regAddr, .regWrData, .splitCfgSel);
  pcm_regs dut (.sys_clk, .rst, .regWrite, .regRead, .regAddr, .regWrData,
    .splitCfgSel, .warmStartDone, .refFailed, .regRdData, .splitOscillatorEnable,
    .splitOscillatorRef, .warmStart, .revisionClear, .pllChannelZeroMode,
    .pllChannelZeroRef, .pllChannelZeroRefForced, .pllChannelZeroHoldover,
    .freqOffsetCapture, .outputRealign);

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] x);
    n_compared++;
    if (s !== x) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic rd(input logic [15:0] a, input logic s, input logic [7:0] x);
    q.push_back(x);
    host.acc(1'b0, a, s, 8'h00);
  endtask

  // --------------------------------
  // read monitor, one cycle latency
  // --------------------------------
  always @(posedge sys_clk) rdSeen <= regRead;
  always @(negedge sys_clk) begin
    if (rdSeen) chk("read", regRdData, q.pop_front());
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    warmStartDone = 1'b0;
    refFailed = 10'h000;
    pen = 1'b0;
    pe = 3'h0;
    void'($urandom(32'h705E));
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    rd(16'h021F, 1'b0, 8'h08);
    rd(16'h021E, 1'b1, 8'h00);
    rd(16'h021E, 1'b0, 8'h00);
    rd(16'h0220, 1'b0, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      r = 4'($urandom_range(15));
      en = i[1];
      host.acc(1'b1, 16'h021E, 1'b1, {r, 3'h7, en});
      chk("warm", warmStart, en != pen);
      chk("splitEn", splitOscillatorEnable, en);
      chk("splitRef", splitOscillatorRef, r < 10 ? r : 4'h0);
      if (en != pen) begin
        @(negedge sys_clk);
        warmStartDone = 1'b1;
        @(negedge sys_clk);
        warmStartDone = 1'b0;
        chk("revClr", revisionClear, 1'b1);
      end
      rd(16'h021E, 1'b1, {r, 3'h0, en});
      pen = en;
    end
    $display("test split oscillator done");
    host.acc(1'b1, 16'h021F, 1'b0, 8'hFF);
    rd(16'h021F, 1'b0, 8'h1A);
    chk("realign", outputRealign, 1'b1);
    host.acc(1'b1, 16'h021F, 1'b0, 8'h10);
    chk("realign", outputRealign, 1'b0);
    for (int i = 0; i < 10; i++) begin
      r = 4'($urandom_range(15));
      host.acc(1'b1, 16'h021E, 1'b0, {r, 1'b1, seq[i]});
      e = seq[i] > 3'h4 ? 3'h3 : seq[i];
      chk("capture", freqOffsetCapture, (e == 1 || e == 4) && !(pe == 1 || pe == 4));
      @(negedge sys_clk);
      chk("mode", pllChannelZeroMode, e);
      chk("forced", pllChannelZeroRefForced, e == 2);
      chk("ref", pllChannelZeroRef, e != 2 ? 4'h0 : r < 10 ? r : 4'h0);
      chk("hold", pllChannelZeroHoldover, e == 1);
      rd(16'h021E, 1'b0, {r, 1'b0, seq[i]});
      pe = e;
    end
    host.acc(1'b1, 16'h021F, 1'b0, 8'h00);
    host.acc(1'b1, 16'h021E, 1'b0, 8'h03);
    host.acc(1'b1, 16'h021E, 1'b0, 8'h01);
    chk("capture", freqOffsetCapture, 1'b0);
    $display("test modes and capture done");
    host.acc(1'b1, 16'h021E, 1'b0, 8'h52);
    refFailed = 10'h3DF;
    @(negedge sys_clk);
    chk("hold", pllChannelZeroHoldover, 1'b0);
    refFailed = 10'h020;
    @(negedge sys_clk);
    chk("hold", pllChannelZeroHoldover, 1'b1);
    $display("test forced failure done");
    close_out();
  end
endmodule // pcm_regs_tb_top
`default_nettype wire
